// File: ebc_defs.vh
// Constants for the external area access configuration block.
`ifndef EBC_DEFS_VH
`define EBC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define EBC_OFS_BUS_WIDTH 16'hfed0
`define EBC_OFS_ACCESS_STATE 16'hfed1
`define EBC_OFS_UPPER_WAIT 16'hfed2

// ****************************************
// Reset values
// ****************************************
`define EBC_RST_WIDTH_WIDE 8'h00
`define EBC_RST_WIDTH_NARROW 8'hff
`define EBC_RST_ACCESS_STATE 8'hff
`define EBC_RST_UPPER_WAIT 8'hff
`define EBC_MODE_WIDE_RESET 3'h4

// ****************************************
// Field positions
// ****************************************
`define EBC_AREA_MSB 23
`define EBC_AREA_LSB 21
`define EBC_WAIT_AREA4_LSB 0

// ****************************************
// Cycle timing counts: states per cycle, and clocks per state tick
// ****************************************
`define EBC_STATES_TWO 3'h2
`define EBC_STATES_THREE 3'h3
`define EBC_STATE_DIV 4'h2

`endif

// File: ebc_cycle_timer.v
// State sequencer for one external bus cycle.
`timescale 1ns/100ps
`include "ebc_defs.vh"

module ebc_cycle_timer (
    clk,
    rst,
    state_tick,
    start,
    three_state,
    wait_states,
    busy_ff,
    in_wait_ff,
    state_num_ff,
    done_ff
);
    input wire clk;
    input wire rst;
    input wire state_tick;
    input wire start;
    input wire three_state;
    input wire [1:0] wait_states;
    output reg busy_ff;
    output reg in_wait_ff;
    output reg [2:0] state_num_ff;
    output reg done_ff;

    reg [2:0] total_ff;
    reg [1:0] waits_ff;
    reg [2:0] nxt_state_num;

    // Waits sit between the second state and the last one.
    always @* begin
        nxt_state_num = state_num_ff + 3'h1;
    end

    always @(posedge clk) begin
        if (rst) begin
            busy_ff <= 1'b0;
            in_wait_ff <= 1'b0;
            state_num_ff <= 3'h0;
            done_ff <= 1'b0;
            total_ff <= 3'h0;
            waits_ff <= 2'h0;
        end else begin
            done_ff <= 1'b0;
            if (start && !busy_ff) begin
                busy_ff <= 1'b1;
                state_num_ff <= 3'h0;
                in_wait_ff <= 1'b0;
                if (three_state) begin
                    total_ff <= `EBC_STATES_THREE + {1'b0, wait_states};
                    waits_ff <= wait_states;
                end else begin
                    total_ff <= `EBC_STATES_TWO;
                    waits_ff <= 2'h0;
                end
            end else if (busy_ff && state_tick) begin
                if (nxt_state_num == total_ff) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    state_num_ff <= 3'h0;
                    in_wait_ff <= 1'b0;
                end else begin
                    state_num_ff <= nxt_state_num;
                    in_wait_ff <= (nxt_state_num >= 3'h2) &&
                        (nxt_state_num < 3'h2 + {1'b0, waits_ff});
                end
            end
        end
    end
endmodule

// File: ebc_area_cfg.v
// Per-area external bus width, access state and wait configuration.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "ebc_defs.vh"


module ebc_area_cfg (
    clk,
    rst,
    mode_pins,
    low_wait_codes,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata_ff,
    acc_req,
    acc_external,
    acc_addr,
    acc_busy_ff,
    acc_done_ff,
    ext_cycle_ff,
    ext_area_ff,
    ext_width8_ff,
    ext_three_state_ff,
    ext_wait_count_ff,
    ext_state_num_ff,
    ext_in_wait_ff,
    ext_addr_ff
);
    parameter ADDR_W = 24;
    parameter STATE_DIV = `EBC_STATE_DIV;

    input wire clk;
    input wire rst;
    input wire [2:0] mode_pins;
    input wire [7:0] low_wait_codes;
    input wire [15:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata_ff;
    input wire acc_req;
    input wire acc_external;
    input wire [ADDR_W-1:0] acc_addr;
    output reg acc_busy_ff;
    output reg acc_done_ff;
    output reg ext_cycle_ff;
    output reg [2:0] ext_area_ff;
    output reg ext_width8_ff;
    output reg ext_three_state_ff;
    output reg [1:0] ext_wait_count_ff;
    output wire [2:0] ext_state_num_ff;
    output wire ext_in_wait_ff;
    output reg [ADDR_W-1:0] ext_addr_ff;

    // ****************************************
    // Helper functions
    // ****************************************

    // Pick a 2-bit wait code for an area from the upper (areas 4-7) or lower (areas 0-3) wait field.
    function [1:0] wait_code;
        input [2:0] area;
        input [7:0] upper;
        input [7:0] lower;
        reg [7:0] sel;
        begin
            sel = area[2] ? upper : lower;
            case (area[1:0])
                2'h0: wait_code = sel[1:0];
                2'h1: wait_code = sel[3:2];
                2'h2: wait_code = sel[5:4];
                default: wait_code = sel[7:6];
            endcase
        end
    endfunction

    // Wait states are the code value itself: 00..11 give 0..3.
    function [1:0] wait_states;
        input [1:0] code;
        begin
            case (code)
                2'b00: wait_states = 2'h0;
                2'b01: wait_states = 2'h1;
                2'b10: wait_states = 2'h2;
                default: wait_states = 2'h3;
            endcase
        end
    endfunction

    // Pick the bit of one area out of an eight-bit per-area field.
    function area_bit;
        input [7:0] flags;
        input [2:0] area;
        begin
            case (area)
                3'h0: area_bit = flags[0];
                3'h1: area_bit = flags[1];
                3'h2: area_bit = flags[2];
                3'h3: area_bit = flags[3];
                3'h4: area_bit = flags[4];
                3'h5: area_bit = flags[5];
                3'h6: area_bit = flags[6];
                default: area_bit = flags[7];
            endcase
        end
    endfunction

    // Bus-width reset value for the operating mode seen at the pins.
    function [7:0] width_reset;
        input [2:0] mode;
        begin
            if (mode == `EBC_MODE_WIDE_RESET) begin
                width_reset = `EBC_RST_WIDTH_WIDE;
            end else begin
                width_reset = `EBC_RST_WIDTH_NARROW;
            end
        end
    endfunction

    // ****************************************
    // Mode pin synchroniser
    // ****************************************
    // The mode pins are asynchronous, so only the second flop is read.
    reg [2:0] mode_meta_ff;
    reg [2:0] mode_sync_ff;

    always @(posedge clk) begin
        mode_meta_ff <= mode_pins;
        mode_sync_ff <= mode_meta_ff;
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    reg [7:0] bus_width_ff;
    reg [7:0] access_state_ff;
    reg [7:0] upper_wait_ff;
    reg width_loaded_ff;
    wire hit_width;
    wire hit_state;
    wire hit_wait;

    // Only the three mapped offsets answer; any other reads as zero.
    assign hit_width = (reg_addr == `EBC_OFS_BUS_WIDTH);
    assign hit_state = (reg_addr == `EBC_OFS_ACCESS_STATE);
    assign hit_wait = (reg_addr == `EBC_OFS_UPPER_WAIT);

    // The width reset value follows the mode caught just after release.
    always @(posedge clk) begin
        if (rst) begin
            bus_width_ff <= `EBC_RST_WIDTH_NARROW;
            width_loaded_ff <= 1'b0;
        end else if (reg_wr && hit_width) begin
            bus_width_ff <= reg_wdata;
            width_loaded_ff <= 1'b1;
        end else if (!width_loaded_ff) begin
            width_loaded_ff <= 1'b1;
            bus_width_ff <= width_reset(mode_sync_ff);
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            access_state_ff <= `EBC_RST_ACCESS_STATE;
            upper_wait_ff <= `EBC_RST_UPPER_WAIT;
        end else if (reg_wr) begin
            if (hit_state) begin
                access_state_ff <= reg_wdata;
            end
            if (hit_wait) begin
                upper_wait_ff <= reg_wdata;
            end
        end
    end

    // ****************************************
    // Register read-back
    // ****************************************

    // Read data stand for the single cycle after the strobe.
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            if (hit_width) begin
                reg_rdata_ff <= bus_width_ff;
            end else if (hit_state) begin
                reg_rdata_ff <= access_state_ff;
            end else if (hit_wait) begin
                reg_rdata_ff <= upper_wait_ff;
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end

    // ****************************************
    // State tick divider
    // ****************************************
    // One bus state lasts STATE_DIV clocks; the tick is a one-cycle enable.
    reg [3:0] div_cnt_ff;
    reg state_tick_ff;

    always @(posedge clk) begin
        if (rst) begin
            div_cnt_ff <= 4'h0;
            state_tick_ff <= 1'b0;
        end else if (div_cnt_ff == STATE_DIV[3:0] - 4'h1) begin
            div_cnt_ff <= 4'h0;
            state_tick_ff <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff + 4'h1;
            state_tick_ff <= 1'b0;
        end
    end

    // ****************************************
    // Access decode
    // ****************************************
    wire [2:0] req_area;
    wire req_three;
    wire [1:0] req_waits;
    reg timer_start_ff;
    wire req_width8;
    wire timer_done;

    assign req_area = acc_addr[`EBC_AREA_MSB:`EBC_AREA_LSB];
    assign req_three = area_bit(access_state_ff, req_area);
    assign req_width8 = area_bit(bus_width_ff, req_area);
    assign req_waits = wait_states(wait_code(req_area, upper_wait_ff,
        low_wait_codes));

    always @(posedge clk) begin
        if (rst) begin
            acc_busy_ff <= 1'b0;
            acc_done_ff <= 1'b0;
            ext_cycle_ff <= 1'b0;
            ext_area_ff <= 3'h0;
            ext_width8_ff <= 1'b0;
            ext_three_state_ff <= 1'b0;
            ext_wait_count_ff <= 2'h0;
            ext_addr_ff <= {ADDR_W{1'b0}};
            timer_start_ff <= 1'b0;
        end else begin
            acc_done_ff <= 1'b0;
            timer_start_ff <= 1'b0;
            if (acc_req && !acc_busy_ff) begin
                if (acc_external) begin
                    acc_busy_ff <= 1'b1;
                    ext_cycle_ff <= 1'b1;
                    ext_area_ff <= req_area;
                    ext_addr_ff <= acc_addr;
                    // A set bit selects 8 bits, a clear one 16 bits.
                    ext_width8_ff <= req_width8;
                    ext_three_state_ff <= req_three;
                    if (req_three) begin
                        ext_wait_count_ff <= req_waits;
                    end else begin
                        ext_wait_count_ff <= 2'h0;
                    end
                    timer_start_ff <= 1'b1;
                end else begin
                    // Internal accesses finish at once, with no waits.
                    acc_done_ff <= 1'b1;
                end
            end else if (timer_done) begin
                acc_busy_ff <= 1'b0;
                ext_cycle_ff <= 1'b0;
                acc_done_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // External cycle sequencer
    // ****************************************
    // Its busy flag stays open: acc_busy_ff already spans the cycle.
    ebc_cycle_timer u_timer (
        .clk(clk),
        .rst(rst),
        .state_tick(state_tick_ff),
        .start(timer_start_ff),
        .three_state(ext_three_state_ff),
        .wait_states(ext_wait_count_ff),
        .busy_ff(),
        .in_wait_ff(ext_in_wait_ff),
        .state_num_ff(ext_state_num_ff),
        .done_ff(timer_done)
    );
endmodule

// File: ebc_area_cfg_sva.sv
// Checker for the external area access configuration block.
`timescale 1ns/100ps
module ebc_area_cfg_chk #(parameter ADDR_W = 24) (
    input wire clk,
    input wire rst,
    input wire reg_rd,
    input wire [7:0] reg_rdata_ff,
    input wire acc_req,
    input wire acc_external,
    input wire [ADDR_W-1:0] acc_addr,
    input wire acc_busy_ff,
    input wire acc_done_ff,
    input wire ext_cycle_ff,
    input wire [2:0] ext_area_ff,
    input wire ext_width8_ff,
    input wire ext_three_state_ff,
    input wire [1:0] ext_wait_count_ff,
    input wire [2:0] ext_state_num_ff,
    input wire ext_in_wait_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata_ff == 8'h00)
        else $error("read data outside read slot");
    a_ext_start_area: assert property (
        acc_req && !acc_busy_ff && acc_external |=> ext_cycle_ff
        && ext_area_ff == $past(acc_addr[ADDR_W-1:ADDR_W-3]))
        else $error("external cycle start or area wrong");
    a_internal_quick: assert property (
        acc_req && !acc_busy_ff && !acc_external |=> acc_done_ff
        && !ext_cycle_ff)
        else $error("internal access misbehaved");
    a_two_state_nowait: assert property (
        ext_cycle_ff && !ext_three_state_ff |->
        ext_wait_count_ff == 2'h0 && !ext_in_wait_ff)
        else $error("wait in two-state cycle");
    a_wait_needs_three: assert property (
        ext_in_wait_ff |-> ext_three_state_ff && ext_wait_count_ff != 2'h0)
        else $error("wait state without three-state setting");
    a_state_bound: assert property (
        ext_cycle_ff |-> ext_state_num_ff < (ext_three_state_ff ?
        3'h3 + {1'b0, ext_wait_count_ff} : 3'h2))
        else $error("state index beyond cycle length");
    a_cfg_steady: assert property (
        ext_cycle_ff && $past(ext_cycle_ff) |->
        $stable(ext_width8_ff) && $stable(ext_wait_count_ff))
        else $error("cycle settings changed mid-cycle");
    a_end_done: assert property (
        $fell(ext_cycle_ff) |-> acc_done_ff)
        else $error("cycle ended without done");
    a_busy_cover: assert property (
        ext_cycle_ff |-> acc_busy_ff)
        else $error("not busy during external cycle");
endmodule

bind ebc_area_cfg ebc_area_cfg_chk #(.ADDR_W(ADDR_W)) chk_u (.clk(clk),
    .rst(rst), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .acc_req(acc_req), .acc_external(acc_external), .acc_addr(acc_addr),
    .acc_busy_ff(acc_busy_ff), .acc_done_ff(acc_done_ff),
    .ext_cycle_ff(ext_cycle_ff), .ext_area_ff(ext_area_ff),
    .ext_width8_ff(ext_width8_ff), .ext_three_state_ff(ext_three_state_ff),
    .ext_wait_count_ff(ext_wait_count_ff),
    .ext_state_num_ff(ext_state_num_ff), .ext_in_wait_ff(ext_in_wait_ff));

// File: ebc_area_mem.sv
// Far-side model that measures each external cycle in clocks.
`timescale 1ns/100ps
module ebc_area_mem (
    input wire clk,
    input wire rst,
    input wire ext_cycle_ff,
    output reg [7:0] len_ff
);
    reg [7:0] cnt_ff;
    always @(posedge clk) begin
        if (rst || !ext_cycle_ff) cnt_ff <= 8'h00;
        else cnt_ff <= cnt_ff + 8'h01;
        if (rst) len_ff <= 8'h00;
        else if (ext_cycle_ff) len_ff <= cnt_ff + 8'h01;
    end
endmodule

// File: test_external_area_access_config.sv
// Self-checking testbench for the area access configuration block.
`timescale 1ns/100ps
`include "ebc_defs.vh"
module test_external_area_access_config;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [2:0] mode_pins = 3'h7;
    reg [7:0] low_wait_codes = 8'h38;
    reg [15:0] reg_addr = 16'h0000;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg acc_req = 1'b0;
    reg acc_external = 1'b0;
    reg [23:0] acc_addr = 24'h00_0000;
    wire [7:0] reg_rdata_ff, len_ff;
    wire acc_busy_ff, acc_done_ff, ext_cycle_ff, ext_width8_ff;
    wire ext_three_state_ff, ext_in_wait_ff;
    wire [2:0] ext_area_ff, ext_state_num_ff;
    wire [1:0] ext_wait_count_ff;
    wire [23:0] ext_addr_ff;
    integer n_mismatch = 0;
    integer checks = 0;
    integer i, n;
    reg w8, ts;
    reg [1:0] wc;
    reg [7:0] base;
    reg [23:0] ad;

    ebc_area_cfg #(.STATE_DIV(1)) dut_u (.clk(clk), .rst(rst),
        .mode_pins(mode_pins), .low_wait_codes(low_wait_codes),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .acc_req(acc_req),
        .acc_external(acc_external), .acc_addr(acc_addr),
        .acc_busy_ff(acc_busy_ff), .acc_done_ff(acc_done_ff),
        .ext_cycle_ff(ext_cycle_ff), .ext_area_ff(ext_area_ff),
        .ext_width8_ff(ext_width8_ff),
        .ext_three_state_ff(ext_three_state_ff),
        .ext_wait_count_ff(ext_wait_count_ff),
        .ext_state_num_ff(ext_state_num_ff),
        .ext_in_wait_ff(ext_in_wait_ff), .ext_addr_ff(ext_addr_ff));
    ebc_area_mem mem_u (.clk(clk), .rst(rst), .ext_cycle_ff(ext_cycle_ff),
        .len_ff(len_ff));

    initial forever #2 clk = ~clk;

    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: saw %h want %h", $time,
                    seen, exp);
            end
        end
    endtask

    task stop_test;
        begin
            if (n_mismatch == 0 && checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task do_reset(input [2:0] m);
        begin
            @(posedge clk);
            rst <= 1'b1;
            mode_pins <= m;
            repeat (10) @(posedge clk);
            rst <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    task wr(input [15:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask

    task rdchk(input [15:0] a, input [7:0] exp);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata_ff, exp);
        end
    endtask

    // Issues one access and waits for its completion pulse.
    task acc(input ext, input [2:0] area);
        begin
            @(posedge clk);
            acc_req <= 1'b1;
            acc_external <= ext;
            acc_addr <= {area, 21'h00_0000};
            @(posedge clk);
            acc_req <= 1'b0;
            #1 w8 = ext_width8_ff;
            ts = ext_three_state_ff;
            wc = ext_wait_count_ff;
            ad = ext_addr_ff;
            i = 0;
            while (acc_done_ff !== 1'b1 && i < 50) begin
                @(posedge clk);
                #1 i = i + 1;
            end
            if (i == 50) chk(8'h01, 8'h00);
        end
    endtask

    task t_regs;
        begin
            rdchk(`EBC_OFS_BUS_WIDTH, 8'hff);
            rdchk(`EBC_OFS_ACCESS_STATE, 8'hff);
            rdchk(`EBC_OFS_UPPER_WAIT, 8'hff);
            rdchk(16'hfed3, 8'h00);
            do_reset(3'h4);
            rdchk(`EBC_OFS_BUS_WIDTH, 8'h00);
            wr(`EBC_OFS_BUS_WIDTH, 8'h5a);
            rdchk(`EBC_OFS_BUS_WIDTH, 8'h5a);
        end
    endtask

    task t_width;
        begin
            wr(`EBC_OFS_BUS_WIDTH, 8'h0f);
            acc(1'b1, 3'h7);
            chk(w8, 8'h00);
            chk(ad[23:16], 8'he0);
            acc(1'b1, 3'h0);
            chk(w8, 8'h01);
            chk(ad[23:16], 8'h00);
        end
    endtask

    task t_timing;
        begin
            wr(`EBC_OFS_ACCESS_STATE, 8'hfb);
            wr(`EBC_OFS_UPPER_WAIT, 8'he4);
            acc(1'b1, 3'h2);
            chk(ts, 8'h00);
            chk(wc, 8'h00);
            base = len_ff;
            for (n = 4; n < 8; n = n + 1) begin
                acc(1'b1, n[2:0]);
                chk(ts, 8'h01);
                chk(wc, n - 4);
                chk(len_ff, base + n - 3);
            end
            acc(1'b1, 3'h1);
            chk(wc, 8'h02);
            base = len_ff;
            acc(1'b0, 3'h7);
            chk(i, 8'h00);
            chk(len_ff, base);
        end
    endtask

    initial begin
        do_reset(3'h7);
        t_regs;
        t_width;
        t_timing;
        stop_test;
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        stop_test;
    end
endmodule
